// ---- tb/addr_mode_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module addr_mode_monitor
   import addr_mode_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire cmd_s cmd,
   input wire logic byteReady,
   input wire logic resValid,
   input wire res_s res
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // legal results only; refused instructions carry no address meaning
   logic ok;
   assign ok = resValid && !res.illegal;

   property p_one; ok && res.mode inside {MODE_INH, MODE_IX0} |-> res.length == 2'h1; endproperty
   a_one: assert property (p_one) else $error("one-byte length wrong");
   property p_imm; ok && res.mode == MODE_IMM |-> res.immValid && !res.eaValid; endproperty
   a_imm: assert property (p_imm) else $error("immediate flags wrong");
   property p_page; ok && res.mode inside {MODE_DIR, MODE_IX0} |-> res.effAddr[15:8] == 8'h00;
   endproperty
   a_page: assert property (p_page) else $error("page zero high byte wrong");
   property p_three; ok && res.mode inside {MODE_EXT, MODE_IX2} |-> res.length == 2'h3; endproperty
   a_three: assert property (p_three) else $error("three-byte length wrong");
   // idle fetch: a no-offset index never asks for operand bytes
   property p_nofetch; cmdValid && cmdReady && cmd.mode == MODE_IX0 |=> !byteReady ##1 resValid;
   endproperty
   a_nofetch: assert property (p_nofetch) else $error("no-offset fetch wrong");
   property p_ix1; ok && res.mode == MODE_IX1 |-> res.effAddr <= 16'h01FE; endproperty
   a_ix1: assert property (p_ix1) else $error("byte offset reach wrong");
   property p_br;
      resValid && res.branchTaken |-> res.mode == MODE_REL && res.nextPc == res.effAddr;
   endproperty
   a_br: assert property (p_br) else $error("branch target wrong");
   property p_ill; cmdValid && cmdReady && cmd.instrIdx >= 6'h3E |-> ##2 resValid && res.illegal;
   endproperty
   a_ill: assert property (p_ill) else $error("out of range index accepted");
endmodule

bind addressing_mode_decoder addr_mode_monitor addr_mode_monitor_inst (
   .clk_sys, .rst, .cmdValid, .cmdReady, .cmd, .byteReady, .resValid, .res);

`default_nettype wire

// ---- tb/fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fetch_model
   import addr_mode_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic byteReady,
   output logic byteValid,
   output byte_t byteData
);
   byte_t q[$];
   logic gap;
   task automatic push(input byte_t b);
      q.push_back(b);
   endtask
   task automatic flush();
      q.delete();
   endtask
   initial begin
      byteValid = 1'b0;
      byteData = 8'h00;
      gap = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // slow memory idles every other cycle; idle data is inverted so stale bytes never pass
   always @(negedge clk_sys) begin
      gap = slow && !gap;
      if (q.size() > 0 && !gap && !rst) begin
         byteValid = 1'b1;
         byteData = q[0];
      end else begin
         byteValid = 1'b0;
         byteData = ~byteData;
      end
   end
   always @(posedge clk_sys) begin
      if (byteValid && byteReady) begin
         void'(q.pop_front());
      end
   end
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import addr_mode_pkg::*;
();
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cmdValid = 1'b0;
   logic resReady = 1'b0;
   logic slow = 1'b0;
   logic cmdReady, byteValid, byteReady, resValid, busy;
   cmd_s cmd = '0;
   byte_t byteData;
   res_s res, r;
   int errCount = 0;
   int nCompared = 0;

   always #12.5 clk_sys = ~clk_sys;

   addressing_mode_decoder addressing_mode_decoder_inst (.clk_sys, .rst, .cmdValid, .cmdReady,
      .cmd, .byteValid, .byteReady, .byteData, .resValid, .resReady, .res, .busy);
   fetch_model fetch_model_inst (.clk_sys, .rst, .slow, .byteReady, .byteValid, .byteData);

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrapUp();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one instruction end to end; bounded waits so a stuck decoder ends the run
   task automatic go(input mode_e m, input logic [5:0] idx, input logic mul, input logic cnd,
      input addr_t op, input byte_t a, input byte_t x, input byte_t b0, input byte_t b1);
      int n;
      fetch_model_inst.flush();
      fetch_model_inst.push(b0);
      fetch_model_inst.push(b1);
      cmd = '{idx, m, mul, cnd, op, a, x};
      cmdValid = 1'b1;
      @(negedge clk_sys);
      cmdValid = 1'b0;
      chk("busy", 16'h0001, {14'h0000, cmdReady, busy});
      n = 0;
      while (!resValid && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 40) begin
         chk("resValid", 16'h0001, 16'(resValid));
         wrapUp();
      end
      r = res;
      chk("mode", 16'(m), 16'(r.mode));
      resReady = 1'b1;
      @(negedge clk_sys);
      resReady = 1'b0;
      chk("idle", 16'h0002, {14'h0000, cmdReady, busy});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_inh();
      go(MODE_INH, 6'h01, 1'b0, 1'b0, 16'h0200, 8'h5A, 8'hC3, 8'h11, 8'h22);
      chk("len", 16'h0001, 16'(r.length));
      chk("pc", 16'h0201, r.nextPc);
      chk("ea", 16'h0000, 16'(r.eaValid));
      chk("mulv", 16'h0000, 16'(r.mulValid));
      chk("regs", 16'hC35A, {r.newX, r.newA});
      go(MODE_INH, 6'h02, 1'b1, 1'b0, 16'h0300, 8'hFF, 8'hFF, 8'h00, 8'h00);
      chk("mul", 16'hFE01, {r.newX, r.newA});
      chk("mulv", 16'h0001, 16'(r.mulValid));
      go(MODE_INH, 6'h02, 1'b1, 1'b0, 16'h0300, 8'h0C, 8'h0D, 8'h00, 8'h00);
      chk("mul", 16'h009C, {r.newX, r.newA});
      $display("inherent done");
   endtask
   task automatic t_mem();
      go(MODE_IMM, 6'h03, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h00, 8'h7E, 8'h99);
      chk("imm", 16'h017E, {7'h00, r.immValid, r.immData});
      chk("pc", 16'h0402, r.nextPc);
      go(MODE_DIR, 6'h04, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h00, 8'hFF, 8'h99);
      chk("ea", 16'h00FF, r.effAddr);
      slow = 1'b1;
      go(MODE_EXT, 6'h05, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h00, 8'h12, 8'h34);
      slow = 1'b0;
      chk("ea", 16'h1234, r.effAddr);
      chk("pc", 16'h0403, r.nextPc);
      go(MODE_IX0, 6'h06, 1'b0, 1'b0, 16'h0400, 8'h00, 8'hFF, 8'h55, 8'h99);
      chk("ea", 16'h00FF, r.effAddr);
      go(MODE_IX1, 6'h07, 1'b0, 1'b0, 16'h0400, 8'h00, 8'hFF, 8'hFF, 8'h99);
      chk("ea", 16'h01FE, r.effAddr);
      go(MODE_IX2, 6'h08, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h80, 8'hFF, 8'hC0);
      chk("ea", 16'h0040, r.effAddr);
      $display("memory modes done");
   endtask
   // offsets at both ends of the span, a branch not taken, and a wrap past the top
   task automatic t_rel();
      addr_t op[4] = '{16'h1000, 16'h1000, 16'h1000, 16'hFFFE};
      byte_t off[4] = '{8'h80, 8'h7F, 8'h7F, 8'h05};
      addr_t pc[4] = '{16'h0F82, 16'h1081, 16'h1002, 16'h0005};
      for (int i = 0; i < 4; i++) begin
         go(MODE_REL, 6'h09, 1'b0, i != 2, op[i], 8'h00, 8'h00, off[i], 8'h99);
         chk("pc", pc[i], r.nextPc);
         chk("taken", 16'(i != 2), 16'(r.branchTaken));
      end
      $display("relative done");
   endtask
   task automatic t_ill();
      go(MODE_DIR, 6'h3E, 1'b0, 1'b0, 16'h0500, 8'h00, 8'h00, 8'h44, 8'h99);
      chk("ill", 16'h0101, {7'h00, r.illegal, 6'h00, r.length});
      go(MODE_DIR, 6'h3D, 1'b0, 1'b0, 16'h0500, 8'h00, 8'h00, 8'h44, 8'h99);
      chk("ill", 16'h0002, {7'h00, r.illegal, 6'h00, r.length});
      go(MODE_DIR, 6'h02, 1'b1, 1'b0, 16'h0500, 8'h03, 8'h04, 8'h44, 8'h99);
      chk("ill", 16'h0101, {7'h00, r.illegal, 6'h00, r.length});
      chk("mulv", 16'h0000, 16'(r.mulValid));
      chk("regs", 16'h0403, {r.newX, r.newA});
      chk("pc", 16'h0501, r.nextPc);
      $display("index range done");
   endtask

   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      t_inh();
      t_mem();
      t_rel();
      t_ill();
      wrapUp();
   end
endmodule

`default_nettype wire

// ---- verilog/addr_mode_pkg.sv ----
package addr_mode_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths and counts
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int INSTR_COUNT = 62;
   localparam logic [5:0] INSTR_LIMIT = 6'h3E;

   // instruction lengths in bytes, opcode included
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // high address byte forced for page-zero modes
   localparam logic [7:0] PAGE_ZERO_HI = 8'h00;

   // values after reset
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] COUNT_RESET = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] byte_t;

   typedef enum logic [2:0] {
      MODE_INH,
      MODE_IMM,
      MODE_DIR,
      MODE_EXT,
      MODE_IX0,
      MODE_IX1,
      MODE_IX2,
      MODE_REL
   } mode_e;

   typedef struct packed {
      logic [5:0] instrIdx;
      mode_e mode;
      logic isMultiply;
      logic condTrue;
      addr_t opcodeAddr;
      byte_t regA;
      byte_t regX;
   } cmd_s;

   typedef struct packed {
      mode_e mode;
      logic [1:0] length;
      logic illegal;
      logic eaValid;
      addr_t effAddr;
      logic immValid;
      byte_t immData;
      logic branchTaken;
      addr_t nextPc;
      logic mulValid;
      byte_t newA;
      byte_t newX;
   } res_s;

   // instruction length for each addressing mode
   function automatic logic [1:0] mode_length(input mode_e m);
      case (m)
         MODE_INH: mode_length = LEN_ONE;
         MODE_IX0: mode_length = LEN_ONE;
         MODE_EXT: mode_length = LEN_THREE;
         MODE_IX2: mode_length = LEN_THREE;
         default: mode_length = LEN_TWO;
      endcase
   endfunction

endpackage

// ---- verilog/addressing_mode_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

//Behaviour
//[RULE1] 62 instructions, each in one of eight modes
//[RULE2] multiply A by X, X high, A low
//[RULE3] inherent: opcode only, no operand bytes
//[RULE4] immediate: two bytes, data byte, no address
//[RULE5] direct: low byte given, high byte zero
//[RULE6] extended: three bytes, high then low address
//[RULE7] no-offset index: one byte, X low, zero high
//[RULE8] indexed 8-bit: X plus byte, may carry
//[RULE9] indexed 16-bit: X plus high/low offset
//[RULE10] relative: branches only, taken adds offset to PC
//[RULE11] signed offset from next instruction address
//[RULE12] 16-bit address sums wrap, carry dropped
module addressing_mode_decoder
   import addr_mode_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire cmd_s cmd,
   input wire logic byteValid,
   output logic byteReady,
   input wire byte_t byteData,
   output logic resValid,
   input wire logic resReady,
   output res_s res,
   output logic busy
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_CALC,
      ST_RESP
   } state_e;

   state_e state_r;
   state_e state_nxt;
   cmd_s cmd_r;
   cmd_s cmd_nxt;
   // operand bytes as fetched: op1 follows the opcode, op2 comes after it
   byte_t op1_r;
   byte_t op1_nxt;
   byte_t op2_r;
   byte_t op2_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [1:0] len_r;
   logic [1:0] len_nxt;
   logic illegal_r;
   logic illegal_nxt;
   res_s res_r;
   res_s res_nxt;
   logic resValid_r;
   logic resValid_nxt;

   logic illegalIn;
   logic [1:0] lenIn;
   logic [1:0] opNeed;
   addr_t seqPc;
   addr_t adderBase;
   addr_t adderOffset;
   addr_t adderSum;
   byte_t mulHi;
   byte_t mulLo;

   // zero-page address from one byte; direct, no-offset and 8-bit index share it
   function automatic addr_t page_zero(input byte_t lo);
      page_zero = {PAGE_ZERO_HI, lo};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // incoming command checks
   // an index past the instruction set, or a multiply in anything but
   // inherent mode, is flagged and fetches no operand bytes
   // a refused instruction still counts one byte so the core can step over it
   always_comb begin
      illegalIn = 1'b0;
      if (cmd.instrIdx >= INSTR_LIMIT) begin // [RULE1]
         illegalIn = 1'b1;
      end else if (cmd.isMultiply && (cmd.mode != MODE_INH)) begin
         illegalIn = 1'b1;
      end
   end

   // length depends on the mode, or is one byte when refused; inherent and no-offset indexed
   // are opcode-only, so they skip fetch entirely
   assign lenIn = illegalIn ? LEN_ONE : mode_length(cmd.mode); // [RULE3] [RULE7]

   // operand bytes still owed after the opcode
   assign opNeed = len_r - LEN_ONE;

   ////////////////////////////////////////////////////////////////////////////
   // shared arithmetic
   // address of the next sequential instruction
   // wraps at the top of memory, like the adder
   assign seqPc = cmd_r.opcodeAddr + {{(ADDR_W-2){1'b0}}, len_r}; // [RULE12]

   // one adder serves both indexed offsets and the branch target;
   // sixteen bits settle easily in a 25 ns cycle, and one adder beats three
   always_comb begin
      adderBase = page_zero(cmd_r.regX);
      adderOffset = {op1_r, op2_r}; // [RULE9]
      case (cmd_r.mode)
         MODE_IX1: begin
            // both unsigned, so the sum tops out at 0x01FE
            adderOffset = page_zero(op1_r); // [RULE8]
         end
         MODE_REL: begin
            // target counts from the byte after the branch
            adderBase = seqPc; // [RULE11]
            adderOffset = {{(ADDR_W-DATA_W){op1_r[DATA_W-1]}}, op1_r}; // [RULE11]
         end
         default: begin
            adderOffset = {op1_r, op2_r};
         end
      endcase
   end

   ea_adder #(
      .W(ADDR_W)
   ) u_ea_adder (
      .base(adderBase),
      .offset(adderOffset),
      .sum(adderSum) // [RULE12]
   );

   // product is combinational and is only used once registered in the result
   unsigned_multiply #(
      .W(DATA_W)
   ) u_unsigned_multiply (
      .multiplicand(cmd_r.regA),
      .multiplier(cmd_r.regX),
      .productHi(mulHi),
      .productLo(mulLo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      op1_nxt = op1_r;
      op2_nxt = op2_r;
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      illegal_nxt = illegal_r;
      res_nxt = res_r;
      resValid_nxt = resValid_r;
      case (state_r)
         ST_IDLE: begin
            // the command is copied whole, so the core may change cmd once taken
            if (cmdValid) begin
               cmd_nxt = cmd;
               len_nxt = lenIn;
               illegal_nxt = illegalIn;
               cnt_nxt = COUNT_RESET;
               op1_nxt = BYTE_RESET;
               op2_nxt = BYTE_RESET;
               if (lenIn == LEN_ONE) begin
                  state_nxt = ST_CALC; // [RULE3]
               end else begin
                  state_nxt = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            // first operand byte is the high half where two follow
            // a stalled memory simply holds us here; any timeout is the core's
            if (byteValid) begin
               if (cnt_r == COUNT_RESET) begin
                  op1_nxt = byteData; // [RULE6]
               end else begin
                  op2_nxt = byteData; // [RULE6]
               end
               // end point is the owed byte count, so two-byte modes stop after one
               cnt_nxt = cnt_r + 2'h1;
               if ((cnt_r + 2'h1) == opNeed) begin
                  state_nxt = ST_CALC;
               end
            end
         end
         ST_CALC: begin
            // defaults describe an instruction that touches nothing: no address,
            // no data, registers handed back unchanged
            res_nxt.mode = cmd_r.mode;
            res_nxt.length = len_r;
            res_nxt.illegal = illegal_r;
            res_nxt.eaValid = 1'b0;
            res_nxt.effAddr = ADDR_RESET;
            res_nxt.immValid = 1'b0;
            res_nxt.immData = BYTE_RESET;
            res_nxt.branchTaken = 1'b0;
            res_nxt.nextPc = seqPc;
            res_nxt.mulValid = 1'b0;
            res_nxt.newA = cmd_r.regA;
            res_nxt.newX = cmd_r.regX;
            if (!illegal_r) begin
               case (cmd_r.mode)
                  MODE_INH: begin
                     if (cmd_r.isMultiply) begin
                        res_nxt.mulValid = 1'b1;
                        res_nxt.newX = mulHi; // [RULE2]
                        res_nxt.newA = mulLo; // [RULE2]
                     end
                  end
                  MODE_IMM: begin
                     // data used as is, no address formed
                     res_nxt.immValid = 1'b1; // [RULE4]
                     res_nxt.immData = op1_r; // [RULE4]
                  end
                  MODE_DIR: begin
                     res_nxt.eaValid = 1'b1;
                     res_nxt.effAddr = page_zero(op1_r); // [RULE5]
                  end
                  MODE_EXT: begin
                     res_nxt.eaValid = 1'b1;
                     res_nxt.effAddr = {op1_r, op2_r}; // [RULE6]
                  end
                  MODE_IX0: begin
                     res_nxt.eaValid = 1'b1;
                     res_nxt.effAddr = page_zero(cmd_r.regX); // [RULE7]
                  end
                  MODE_IX1: begin
                     // reaches up to one past the first page
                     res_nxt.eaValid = 1'b1;
                     res_nxt.effAddr = adderSum; // [RULE8]
                  end
                  MODE_IX2: begin
                     res_nxt.eaValid = 1'b1;
                     res_nxt.effAddr = adderSum; // [RULE9]
                  end
                  default: begin
                     // branch target reported even when not taken
                     // a branch not taken falls through to the sequential address
                     res_nxt.effAddr = adderSum;
                     res_nxt.branchTaken = cmd_r.condTrue; // [RULE10]
                     if (cmd_r.condTrue) begin
                        res_nxt.nextPc = adderSum; // [RULE10]
                     end
                  end
               endcase
            end
            resValid_nxt = 1'b1;
            state_nxt = ST_RESP;
         end
         default: begin
            // result stands until taken
            // a new command is refused until then, so results never mix
            if (resReady) begin
               resValid_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer registers
   // results clear to zero so nothing reads as a valid address after reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cmd_r <= '0;
         op1_r <= BYTE_RESET;
         op2_r <= BYTE_RESET;
         cnt_r <= COUNT_RESET;
         len_r <= LEN_ONE;
         illegal_r <= 1'b0;
         res_r <= '0;
         resValid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         op1_r <= op1_nxt;
         op2_r <= op2_nxt;
         cnt_r <= cnt_nxt;
         len_r <= len_nxt;
         illegal_r <= illegal_nxt;
         res_r <= res_nxt;
         resValid_r <= resValid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // cmdReady and byteReady are decoded from state; resValid and result data are registered
   // busy spans fetch too, so the core can hold its program counter
   assign cmdReady = (state_r == ST_IDLE);
   assign byteReady = (state_r == ST_FETCH);
   assign resValid = resValid_r;
   assign res = res_r;
   assign busy = (state_r != ST_IDLE);

endmodule

`default_nettype wire

// ---- verilog/ea_adder.sv ----
`timescale 1ns/1ps
`default_nettype none

module ea_adder #(
   parameter int W = 16
) (
   input wire logic [W-1:0] base,
   input wire logic [W-1:0] offset,
   output logic [W-1:0] sum
);

   logic [W:0] fullSum;

   // carry out of the top bit is dropped, so addresses wrap
   assign fullSum = {1'b0, base} + {1'b0, offset};
   assign sum = fullSum[W-1:0];

endmodule

`default_nettype wire

// ---- verilog/unsigned_multiply.sv ----
`timescale 1ns/1ps
`default_nettype none

module unsigned_multiply #(
   parameter int W = 8
) (
   input wire logic [W-1:0] multiplicand,
   input wire logic [W-1:0] multiplier,
   output logic [W-1:0] productHi,
   output logic [W-1:0] productLo
);

   logic [2*W-1:0] product;

   // both operands unsigned, full double-width product
   assign product = multiplicand * multiplier;
   assign productHi = product[2*W-1:W];
   assign productLo = product[W-1:0];

endmodule

`default_nettype wire
